// [wdc_defines.vh]
// constants for the watchdog period control block
`ifndef WDC_DEFINES_VH
`define WDC_DEFINES_VH

// register byte offsets
`define WDC_OFF_CTRL 12'h000
`define WDC_OFF_CFG 12'h004
`define WDC_OFF_STAT 12'h008
`define WDC_OFF_RST 12'h00c

// control register fields and reset value
`define WDC_CTRL_RESET 8'h16
`define WDC_CTRL_MASK 8'h3f
`define WDC_PS_MSB 5
`define WDC_PS_LSB 1
`define WDC_EN_BIT 0
`define WDC_PS_MAX 5'h12
`define WDC_PS_BASE_LOG2 5

// configuration mode codes
`define WDC_MODE_OFF 2'h0
`define WDC_MODE_SOFT 2'h1
`define WDC_MODE_RUN_AWAKE 2'h2
`define WDC_MODE_ON 2'h3

// reset source bit positions
`define WDC_SRC_POR 0
`define WDC_SRC_BOR 1
`define WDC_SRC_LOW_POWER_BROWNOUT_RESET 2
`define WDC_SRC_PIN 3
`define WDC_SRC_WDOG 4
`define WDC_SRC_INSTR 5
`define WDC_SRC_STKOVF 6
`define WDC_SRC_STKUNF 7
`define WDC_SRC_PROG 8
`define WDC_NSRC 9

// timing
`define WDC_LFOSC_HZ 31000
`define WDC_MCLK_HZ 10000000
`define WDC_PWRT_MS 64
`define WDC_RST_PULSE 8'h04

`endif

// [wdc_top.v]
// watchdog period control with reset sources and power-up timer
//
// Overview of operation
// R1 - period code 0 gives 1:32, each step doubles to 1:8388608; codes above 10010 give 1:32
// R2 - watchdog time base is the slow internal oscillator near 31 kHz, so intervals approximate
// R3 - soft enable bit counts only in software-control mode: 1 runs, 0 stops
// R4 - reset sources: power-on, brown-out, low-power brown-out, pin, watchdog, instruction, stack, programming
// R5 - optional power-up timer stretches reset after power-on or brown-out
// R6 - two top bits of the control register read as zero
// R7 - watchdog reset fires when counter reaches the selected interval uncleared
`timescale 1ns/1ps
`default_nettype none
`include "wdc_defines.vh"

module wdc_top #(
	parameter PWRT_CYCLES = (`WDC_PWRT_MS * (`WDC_MCLK_HZ / 1000)),
	parameter LF_DIV = (`WDC_MCLK_HZ / `WDC_LFOSC_HZ)
)
(
	input wire mclk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output reg [31:0] prdata,
	input wire [1:0] wdog_config_mode,
	input wire power_up_timer_enable,
	input wire sleeping,
	input wire wdog_clear,
	input wire power_on_event,
	input wire brownout_reset,
	input wire low_power_brownout_reset,
	input wire external_reset_pin_n,
	input wire reset_instr,
	input wire stack_overflow,
	input wire stack_underflow,
	input wire prog_mode_exit,
	output reg device_reset_q,
	output reg wdog_timeout_q
);

// ----------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------
reg [`WDC_NSRC-1:0] src_s1_q;
reg [`WDC_NSRC-1:0] src_s2_q;
reg [4:0] ctl_s1_q;
reg [4:0] ctl_s2_q;
wire [`WDC_NSRC-1:0] src_raw;
wire wdog_fire;

assign src_raw = {prog_mode_exit, stack_underflow, stack_overflow, reset_instr, 1'b0,
	~external_reset_pin_n, low_power_brownout_reset, brownout_reset, power_on_event};

always @(posedge mclk or negedge nrst)
begin
	if (!nrst)
	begin
		src_s1_q <= {`WDC_NSRC{1'b0}};
		src_s2_q <= {`WDC_NSRC{1'b0}};
		ctl_s1_q <= 5'h00;
		ctl_s2_q <= 5'h00;
	end
	else
	begin
		src_s1_q <= src_raw;
		src_s2_q <= src_s1_q;
		ctl_s1_q <= {wdog_config_mode, power_up_timer_enable, sleeping, wdog_clear};
		ctl_s2_q <= ctl_s1_q;
	end
end

wire [1:0] mode_s = ctl_s2_q[4:3];
wire pwrt_en_s = ctl_s2_q[2];
wire sleep_s = ctl_s2_q[1];
wire clear_s = ctl_s2_q[0];

// ----------------------------------------------------------------
// apb register access
// ----------------------------------------------------------------
reg [7:0] ctrl_q;
reg [`WDC_NSRC-1:0] cause_q;
reg [23:0] wdog_cnt_q;
wire wr_en = psel & penable & pwrite;
wire sel_ctrl = (paddr == `WDC_OFF_CTRL);
wire sel_cfg = (paddr == `WDC_OFF_CFG);
wire sel_stat = (paddr == `WDC_OFF_STAT);
wire sel_rst = (paddr == `WDC_OFF_RST);
wire mapped = sel_ctrl | sel_cfg | sel_stat | sel_rst;
wire wdog_run;

assign pready = 1'b1;
assign pslverr = psel & penable & ~mapped;

reg [7:0] ctrl_d;

always @*
begin
	ctrl_d = ctrl_q;
	if (wr_en && sel_ctrl)
		ctrl_d = pwdata[7:0] & `WDC_CTRL_MASK; // [R6]
end

always @(posedge mclk or negedge nrst)
begin
	if (!nrst)
		ctrl_q <= `WDC_CTRL_RESET;
	else
		ctrl_q <= ctrl_d;
end

always @*
begin
	prdata = 32'h00000000;
	if (psel && !pwrite)
	begin
		if (sel_ctrl)
			prdata = {24'h000000, ctrl_q & `WDC_CTRL_MASK}; // [R6]
		else if (sel_cfg)
			prdata = {28'h0000000, mode_s, pwrt_en_s, wdog_run};
		else if (sel_stat)
			prdata = {8'h00, wdog_cnt_q};
		else if (sel_rst)
			prdata = {23'h000000, cause_q};
	end
end

// ----------------------------------------------------------------
// period decode and enable
// ----------------------------------------------------------------
function [23:0] wdc_limit;
	input [4:0] code;
	reg [4:0] c;
	begin
		c = (code > `WDC_PS_MAX) ? 5'h00 : code; // [R1]
		wdc_limit = 24'h000001 << (c + `WDC_PS_BASE_LOG2); // [R1]
	end
endfunction

wire [4:0] period_code = ctrl_q[`WDC_PS_MSB:`WDC_PS_LSB];
wire soft_wdog_enable = ctrl_q[`WDC_EN_BIT];
wire [23:0] wdog_limit = wdc_limit(period_code);

assign wdog_run = (mode_s == `WDC_MODE_ON) ||
	((mode_s == `WDC_MODE_RUN_AWAKE) && !sleep_s) ||
	((mode_s == `WDC_MODE_SOFT) && soft_wdog_enable); // [R3]

// ----------------------------------------------------------------
// low frequency tick and watchdog counter
// ----------------------------------------------------------------
reg [15:0] lf_div_q;
wire lf_tick = (lf_div_q == LF_DIV - 1);

reg [15:0] lf_div_d;

always @*
begin
	if (lf_tick)
		lf_div_d = 16'h0000; // [R2]
	else
		lf_div_d = lf_div_q + 16'h0001;
end

always @(posedge mclk or negedge nrst)
begin
	if (!nrst)
		lf_div_q <= 16'h0000;
	else
		lf_div_q <= lf_div_d;
end

assign wdog_fire = wdog_run && lf_tick && (wdog_cnt_q >= wdog_limit - 24'h000001); // [R7]

reg [23:0] wdog_cnt_d;

always @*
begin
	wdog_cnt_d = wdog_cnt_q;
	if (!wdog_run || clear_s || device_reset_q || (wr_en && sel_ctrl))
		wdog_cnt_d = 24'h000000; // [R3]
	else if (wdog_fire)
		wdog_cnt_d = 24'h000000; // [R7]
	else if (lf_tick)
		wdog_cnt_d = wdog_cnt_q + 24'h000001; // [R2]
end

always @(posedge mclk or negedge nrst)
begin
	if (!nrst)
		wdog_cnt_q <= 24'h000000;
	else
		wdog_cnt_q <= wdog_cnt_d;
end

// ----------------------------------------------------------------
// reset sources and power-up timer
// ----------------------------------------------------------------
localparam ST_IDLE = 3'b001;
localparam ST_PWRT = 3'b010;
localparam ST_HOLD = 3'b100;

reg [2:0] state_q;
reg [31:0] rcnt_q;
wire [`WDC_NSRC-1:0] src_now = src_s2_q | ({{(`WDC_NSRC-1){1'b0}}, wdog_fire} << `WDC_SRC_WDOG); // [R4]
wire power_evt = src_now[`WDC_SRC_POR] | src_now[`WDC_SRC_BOR];
wire any_evt = |src_now; // [R4]

reg [`WDC_NSRC-1:0] cause_d;

always @*
begin
	cause_d = cause_q;
	if (wr_en && sel_rst)
		cause_d = cause_q & ~pwdata[`WDC_NSRC-1:0];
	// a new event beats a same-cycle clear
	cause_d = cause_d | src_now; // [R4]
end

always @(posedge mclk or negedge nrst)
begin
	if (!nrst)
		cause_q <= {`WDC_NSRC{1'b0}};
	else
		cause_q <= cause_d;
end

// ----------------------------------------------------------------
// reset hold state machine
// ----------------------------------------------------------------
function [31:0] wdc_hold_len;
	input pwrt_req;
	begin
		if (pwrt_req)
			wdc_hold_len = PWRT_CYCLES; // [R5]
		else
			wdc_hold_len = {24'h000000, `WDC_RST_PULSE}; // [R4]
	end
endfunction

reg [2:0] state_d;
reg [31:0] rcnt_d;
reg device_reset_d;
wire [31:0] hold_len = wdc_hold_len(power_evt && pwrt_en_s);

always @*
begin
	state_d = state_q;
	rcnt_d = rcnt_q;
	device_reset_d = device_reset_q;
	case (state_q)
	ST_IDLE:
	begin
		if (any_evt)
		begin
			state_d = (power_evt && pwrt_en_s) ? ST_PWRT : ST_HOLD; // [R5]
			rcnt_d = hold_len;
			device_reset_d = 1'b1; // [R4]
		end
	end
	ST_PWRT, ST_HOLD:
	begin
		if (any_evt)
		begin
			// a later short event never cuts a running power-up wait
			if (hold_len > rcnt_q)
				rcnt_d = hold_len;
			if (power_evt && pwrt_en_s)
				state_d = ST_PWRT; // [R5]
		end
		else if (rcnt_q <= 32'h00000001)
		begin
			state_d = ST_IDLE;
			device_reset_d = 1'b0;
		end
		else
			rcnt_d = rcnt_q - 32'h00000001; // [R5]
	end
	default:
	begin
		state_d = ST_IDLE;
		device_reset_d = 1'b0;
	end
	endcase
end

always @(posedge mclk or negedge nrst)
begin
	if (!nrst)
	begin
		state_q <= ST_IDLE;
		rcnt_q <= 32'h00000000;
		device_reset_q <= 1'b0;
		wdog_timeout_q <= 1'b0;
	end
	else
	begin
		state_q <= state_d;
		rcnt_q <= rcnt_d;
		device_reset_q <= device_reset_d;
		wdog_timeout_q <= wdog_fire; // [R7]
	end
end

endmodule
`default_nettype wire

// [wdc_asserts.sv]
// port assertions for the watchdog period control block
`timescale 1ns/1ps
`default_nettype none
module wdc_asserts (
	input wire mclk,
	input wire nrst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire pready,
	input wire pslverr,
	input wire [31:0] prdata,
	input wire external_reset_pin_n,
	input wire device_reset_q,
	input wire wdog_timeout_q
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	property p_rdy; pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready low");
	property p_err;
		pslverr |-> psel && penable && paddr != 12'h000 && paddr != 12'h004 && paddr != 12'h008 && paddr != 12'h00c;
	endproperty
	a_err: assert property (p_err) else $error("pslverr on mapped address");
	property p_hi; psel && !pwrite && paddr == 12'h000 |-> prdata[31:6] == 26'h0; endproperty
	a_hi: assert property (p_hi) else $error("control upper bits not zero");
	property p_zero; psel && penable && !pwrite && pslverr |-> prdata == 32'h0; endproperty
	a_zero: assert property (p_zero) else $error("unmapped read not zero");
	property p_pulse; wdog_timeout_q |=> !wdog_timeout_q; endproperty
	a_pulse: assert property (p_pulse) else $error("timeout pulse too long");
	property p_fire; wdog_timeout_q |=> device_reset_q; endproperty
	a_fire: assert property (p_fire) else $error("timeout gave no reset");
	property p_hold; $rose(device_reset_q) |-> device_reset_q [*4]; endproperty
	a_hold: assert property (p_hold) else $error("reset too short");
	property p_pin; $fell(external_reset_pin_n) |-> ##[1:5] device_reset_q; endproperty
	a_pin: assert property (p_pin) else $error("pin gave no reset");
	c_to: cover property (wdog_timeout_q);
	c_err: cover property (pslverr);
	c_rst: cover property ($rose(device_reset_q));
endmodule
bind wdc_top wdc_asserts u_chk (
	.mclk(mclk),
	.nrst(nrst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pready(pready),
	.pslverr(pslverr),
	.prdata(prdata),
	.external_reset_pin_n(external_reset_pin_n),
	.device_reset_q(device_reset_q),
	.wdog_timeout_q(wdog_timeout_q)
);
`default_nettype wire

// [tb_wdc_top.sv]
// self-checking testbench for the watchdog period control block
`timescale 1ns/1ps
`default_nettype none
module tb_wdc_top;
	logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, power_up_timer_enable = 0, sleeping = 0;
	logic wdog_clear = 0, external_reset_pin_n = 1, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	logic [1:0] wdog_config_mode = 2'h1;
	logic [6:0] src = 7'h00;
	logic [75:0] rows [4] = '{{12'h000, 32'hff, 32'h3f}, {12'h000, 32'h25, 32'h25}, {12'h010, 32'h5, 32'h0},
		{12'h004, 32'hff, 32'h5}};
	logic [4:0] codes [3] = '{5'h00, 5'h01, 5'h13};
	int cause_bit [9] = '{8, 7, 6, 5, 2, 1, 0, 3, 0};
	wire power_on_event, brownout_reset, low_power_brownout_reset, reset_instr, stack_overflow, stack_underflow;
	wire prog_mode_exit, pready, pslverr, device_reset_q, wdog_timeout_q;
	wire [31:0] prdata;
	int mismatches = 0, check_count = 0, c, e;
	assign {power_on_event, brownout_reset, low_power_brownout_reset, reset_instr, stack_overflow, stack_underflow,
		prog_mode_exit} = src;
	wdc_top #(.PWRT_CYCLES(20), .LF_DIV(4)) DUT (
		.mclk(mclk),
		.nrst(nrst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pready(pready),
		.pslverr(pslverr),
		.prdata(prdata),
		.wdog_config_mode(wdog_config_mode),
		.power_up_timer_enable(power_up_timer_enable),
		.sleeping(sleeping),
		.wdog_clear(wdog_clear),
		.power_on_event(power_on_event),
		.brownout_reset(brownout_reset),
		.low_power_brownout_reset(low_power_brownout_reset),
		.external_reset_pin_n(external_reset_pin_n),
		.reset_instr(reset_instr),
		.stack_overflow(stack_overflow),
		.stack_underflow(stack_underflow),
		.prog_mode_exit(prog_mode_exit),
		.device_reset_q(device_reset_q),
		.wdog_timeout_q(wdog_timeout_q)
	);
	always #50 mclk = ~mclk;
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cmp(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x)
		begin
			mismatches++;
			$display("[ERR] %0t got %h want %h", $time, g, x);
		end
	endtask
	task automatic ok(input logic b);
		cmp({31'h0, b}, 32'h1);
	endtask
	task automatic tmo(input int lim);
		c = 0;
		while (wdog_timeout_q !== 1'b1 && c < lim)
		begin
			@(negedge mclk);
			c++;
		end
	endtask
	task automatic summarize;
		$display("mismatches %0d checks %0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		#2000000;
		mismatches++;
		summarize;
	end
	initial
	begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		apb(0, 12'h000, 32'h0);
		cmp(rd, 32'h16);
		foreach (rows[i])
		begin
			apb(1, rows[i][75:64], rows[i][63:32]);
			ok(err === (rows[i][75:64] == 12'h010));
			apb(0, rows[i][75:64], 32'h0);
			cmp(rd, rows[i][31:0]);
		end
		foreach (codes[i])
		begin
			apb(1, 12'h000, {26'h0, codes[i], 1'b1});
			e = (codes[i] > 5'h12 ? 32 : 32 << codes[i]) * 4;
			tmo(3000);
			ok(c >= e - 4 && c <= e + 12);
		end
		apb(1, 12'h000, 32'h0);
		tmo(400);
		ok(c == 400);
		@(posedge mclk);
		wdog_config_mode <= 2'h3;
		tmo(400);
		ok(c >= 124 && c <= 140);
		@(posedge mclk);
		wdog_config_mode <= 2'h0;
		apb(1, 12'h000, 32'h1);
		tmo(400);
		ok(c == 400);
		apb(0, 12'h008, 32'h0);
		cmp(rd, 32'h0);
		@(posedge mclk);
		wdog_config_mode <= 2'h2;
		sleeping <= 1'b1;
		tmo(400);
		ok(c == 400);
		@(posedge mclk);
		sleeping <= 1'b0;
		wdog_clear <= 1'b1;
		tmo(300);
		ok(c == 300);
		@(posedge mclk);
		wdog_clear <= 1'b0;
		tmo(400);
		ok(c >= 124 && c <= 140);
		apb(1, 12'h000, 32'h0);
		@(posedge mclk);
		wdog_config_mode <= 2'h1;
		repeat (30) @(posedge mclk);
		apb(0, 12'h00c, 32'h0);
		cmp(rd, 32'h10);
		apb(1, 12'h00c, 32'h1ff);
		apb(0, 12'h00c, 32'h0);
		cmp(rd, 32'h0);
		for (int i = 0; i < 9; i++)
		begin
			power_up_timer_enable <= i == 8;
			repeat (4) @(posedge mclk);
			src <= i < 7 ? 7'h01 << i : {i == 8, 6'h00};
			external_reset_pin_n <= i != 7;
			repeat (3) @(posedge mclk);
			src <= 7'h00;
			external_reset_pin_n <= 1'b1;
			e = 0;
			repeat (40) @(negedge mclk) e += device_reset_q;
			ok(i == 8 ? e >= 16 && e <= 30 : e >= 4 && e <= 10);
			apb(0, 12'h00c, 32'h0);
			cmp(rd, 32'h1 << cause_bit[i]);
			apb(1, 12'h00c, 32'h1ff);
		end
		@(posedge mclk);
		nrst <= 1'b0;
		repeat (3) @(posedge mclk);
		ok(device_reset_q === 1'b0 && wdog_timeout_q === 1'b0);
		nrst <= 1'b1;
		apb(0, 12'h000, 32'h0);
		cmp(rd, 32'h16);
		apb(0, 12'h00c, 32'h0);
		cmp(rd, 32'h0);
		summarize;
	end
endmodule
`default_nettype wire
